// ===== rtl/mmbd_consts.svh
`ifndef MMBD_CONSTS_SVH
`define MMBD_CONSTS_SVH
// Register byte addresses on APB (printed offset times four)
`define MMBD_IDX_PCL 7'h02
`define MMBD_IDX_FLAGS 7'h03
`define MMBD_IDX_PTR 7'h04
`define MMBD_IDX_PCH 7'h0a
`define MMBD_IDX_INDIRECT 7'h00
`define MMBD_ADDR_PCL 12'h008
`define MMBD_ADDR_FLAGS 12'h00c
`define MMBD_ADDR_PTR 12'h010
`define MMBD_ADDR_PCH 12'h028
`define MMBD_ADDR_CTRL 12'h100
`define MMBD_ADDR_PC 12'h104
`define MMBD_ADDR_PMRD 12'h108
`define MMBD_ADDR_DACC 12'h10c
// Field positions
`define MMBD_BANK_HI_BIT 6
`define MMBD_BANK_LO_BIT 5
// Memory layout
`define MMBD_PC_W 13
`define MMBD_PM_AW 11
`define MMBD_PM_WORDS 2048
`define MMBD_RESET_VEC 13'h0000
`define MMBD_IRQ_VEC 13'h0004
`define MMBD_GPR_FIRST 7'h20
`define MMBD_GPR_WORDS 96
`define MMBD_FLAGS_RST 8'h18
`define MMBD_CLKDIV 1'b1
`endif

// ===== rtl/mmbd_pkg.sv
package mmbd_pkg;
   typedef struct packed {
      logic [12:0] pc;
      logic [7:0] flags;
      logic [7:0] ptr;
      logic [4:0] pch;
      logic [1:0] div;
      logic clko;
      logic [1:0] master_clear_n_sync;
      logic pready;
      logic [31:0] prdata;
      logic [13:0] fetch_word;
      logic [8:0] daddr;
      logic [7:0] dread;
      logic rc_mode;
   } mmbd_state_t;

   typedef struct packed {
      logic fetch;
      logic irq_take;
      logic [13:0] instr_word;
   } mmbd_fetch_t;
endpackage

// ===== rtl/mmbd_memory_map_bank_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "mmbd_consts.svh"
// Summary of operation
// - Program counter is 13 bits wide, an 8K by 14 space.
// - Only words 0000h-07FFh exist; higher addresses wrap onto them.
// - Reset starts at 0000h and an accepted interrupt goes to 0004h.
// - Flag bits 6 and 5 select data banks 0 to 3.
// - Each bank spans 128 byte offsets from the low seven operand bits.
// - Low offsets decode to special registers, higher ones to RAM.
// - Core registers are mirrored, flags present in all four banks.
// - Data can be reached directly or through the indirect pointer.
// - Program and data paths are separate and work in one cycle.
// - In RC mode a clock out runs at one quarter of the input rate.
// - A low master clear holds the block in reset except the RC mode bit, which only reset clears.
// - Software can read program memory words as data.
// - Offset zero in any bank accesses the address in the pointer.
// - Upper PC bits load from the holding latch on a low byte write.
module mmbd_memory_map_bank_decode (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic master_clear_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Core fetch port
   input wire logic fetch,
   input wire logic irq_take,
   input wire logic [13:0] pm_wdata,
   input wire logic pm_we,
   output logic [13:0] fetch_word,
   // Oscillator clock out and data address out
   output logic quarter_rate_clock_out,
   output logic [8:0] data_addr_out
);
   mmbd_pkg::mmbd_state_t st_ff, nxt_st;
   logic [13:0] pmem [0:`MMBD_PM_WORDS-1];
   // Two halves, bank 0 and bank 1, picked by effective address bit 7 (bank lo bit when direct, pointer bit 7 when indirect)
   logic [7:0] gpr [0:255];
   logic [7:0] sfr_misc [0:31];
   logic [8:0] eff;
   logic [6:0] off;
   logic is_gpr;
   logic [7:0] gidx;
   logic [7:0] dval;
   logic acc;
   logic wr;
   logic rst_all;
   logic [11:0] a;
   logic [10:0] pm_idx;
   logic [7:0] wb;

   assign rst_all = reset | ~st_ff.master_clear_n_sync[1];
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign a = paddr;
   assign wb = pwdata[7:0];
   // Indirect slot resolves through the pointer, with bit 8 from bank hi
   always_comb begin
      off = pwdata[14:8];
      eff = {st_ff.flags[`MMBD_BANK_HI_BIT], st_ff.flags[`MMBD_BANK_LO_BIT],
             off};
      if (off == `MMBD_IDX_INDIRECT) begin
         eff = {st_ff.flags[`MMBD_BANK_HI_BIT], st_ff.ptr};
      end
   end
   // Banks 2/3 fold onto 0/1 RAM
   assign is_gpr = eff[6:0] >= `MMBD_GPR_FIRST;
   assign gidx = {eff[7], 7'(eff[6:0] - `MMBD_GPR_FIRST)};

   always_comb begin
      dval = 8'h00;
      if (is_gpr) begin
         dval = gpr[gidx];
      end else begin
         case (eff[6:0])
            `MMBD_IDX_PCL: dval = st_ff.pc[7:0];
            `MMBD_IDX_FLAGS: dval = st_ff.flags;
            `MMBD_IDX_PTR: dval = st_ff.ptr;
            `MMBD_IDX_PCH: dval = {3'h0, st_ff.pch};
            `MMBD_IDX_INDIRECT: dval = 8'h00;
            default: dval = sfr_misc[eff[4:0]];
         endcase
      end
   end

   assign pm_idx = st_ff.pc[`MMBD_PM_AW-1:0];

   always_comb begin
      nxt_st = st_ff;
      nxt_st.master_clear_n_sync = {st_ff.master_clear_n_sync[0], master_clear_n};
      nxt_st.pready = 1'b0;
      nxt_st.div = 2'(st_ff.div + 2'h1);
      // Toggle every second clock: period of four clocks
      if (st_ff.rc_mode && st_ff.div[0] == `MMBD_CLKDIV) begin
         nxt_st.clko = ~st_ff.clko;
      end else if (!st_ff.rc_mode) begin
         nxt_st.clko = 1'b0;
      end
      if (irq_take) begin
         nxt_st.pc = `MMBD_IRQ_VEC;
      end else if (fetch) begin
         nxt_st.fetch_word = pmem[pm_idx];
         nxt_st.pc = 13'(st_ff.pc + 13'h1);
      end
      if (acc && !st_ff.pready) begin
         nxt_st.pready = 1'b1;
         nxt_st.prdata = 32'h0;
         case (a)
            `MMBD_ADDR_PCL: nxt_st.prdata = {24'h0, st_ff.pc[7:0]};
            `MMBD_ADDR_FLAGS: nxt_st.prdata = {24'h0, st_ff.flags};
            `MMBD_ADDR_PTR: nxt_st.prdata = {24'h0, st_ff.ptr};
            `MMBD_ADDR_PCH: nxt_st.prdata = {27'h0, st_ff.pch};
            `MMBD_ADDR_CTRL: nxt_st.prdata = {31'h0, st_ff.rc_mode};
            `MMBD_ADDR_PC: nxt_st.prdata = {19'h0, st_ff.pc};
            `MMBD_ADDR_PMRD: nxt_st.prdata = {18'h0, pmem[pwdata[10:0]]};
            `MMBD_ADDR_DACC: begin
               nxt_st.prdata = {15'h0, eff, dval};
               nxt_st.daddr = eff;
            end
            default: nxt_st.prdata = 32'h0;
         endcase
         if (wr) begin
            case (a)
               `MMBD_ADDR_PCL:
                  nxt_st.pc = {st_ff.pch, wb};
               `MMBD_ADDR_FLAGS: nxt_st.flags = wb;
               `MMBD_ADDR_PTR: nxt_st.ptr = wb;
               `MMBD_ADDR_PCH: nxt_st.pch = wb[4:0];
               `MMBD_ADDR_CTRL: nxt_st.rc_mode = pwdata[0];
               `MMBD_ADDR_DACC: begin
                  nxt_st.daddr = eff;
                  if (!is_gpr) begin
                     case (eff[6:0])
                        `MMBD_IDX_PCL: nxt_st.pc = {st_ff.pch, wb};
                        `MMBD_IDX_FLAGS: nxt_st.flags = wb;
                        `MMBD_IDX_PTR: nxt_st.ptr = wb;
                        `MMBD_IDX_PCH: nxt_st.pch = wb[4:0];
                        default: nxt_st.daddr = eff;
                     endcase
                  end
               end
               default: nxt_st.daddr = st_ff.daddr;
            endcase
         end
      end
      if (rst_all) begin
         nxt_st.pc = `MMBD_RESET_VEC;
         nxt_st.flags = `MMBD_FLAGS_RST;
         nxt_st.ptr = 8'h00;
         nxt_st.pch = 5'h00;
         nxt_st.pready = 1'b0;
         nxt_st.prdata = 32'h0;
         nxt_st.fetch_word = 14'h0;
         nxt_st.daddr = 9'h0;
         nxt_st.div = 2'h0;
         nxt_st.clko = 1'b0;
      end
      if (reset) begin
         nxt_st.master_clear_n_sync = 2'h0;
         nxt_st.rc_mode = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en) begin
         st_ff <= nxt_st;
         if (!rst_all && pm_we) begin
            pmem[st_ff.pc[`MMBD_PM_AW-1:0]] <= pm_wdata;
         end
         if (!rst_all && wr && !st_ff.pready && a == `MMBD_ADDR_DACC) begin
            if (is_gpr) begin
               gpr[gidx] <= wb;
            end else if (eff[6:5] == 2'h0) begin
               sfr_misc[eff[4:0]] <= wb;
            end
         end
      end
   end

   assign pready = st_ff.pready;
   assign prdata = st_ff.prdata;
   assign pslverr = 1'b0;
   assign fetch_word = st_ff.fetch_word;
   assign quarter_rate_clock_out = st_ff.clko;
   assign data_addr_out = st_ff.daddr;
endmodule
`default_nettype wire

// ===== sim/mmbd_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "mmbd_consts.svh"
module mmbd_checker (
   // Watched ports
   input wire logic clk, reset, master_clear_n, psel, penable, pready,
   input wire logic pslverr, fetch, quarter_rate_clock_out,
   input wire logic [11:0] paddr,
   input wire logic [13:0] fetch_word,
   input wire logic [8:0] data_addr_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset || !master_clear_n);
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   a_ready_bound: assert property (s_wait |-> ##[1:2] pready)
      else $error("access not answered");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   a_no_error: assert property (pslverr == 1'b0)
      else $error("error response seen");
   a_clko_hold: assert property ($changed(quarter_rate_clock_out) |=>
      $stable(quarter_rate_clock_out) [*1])
      else $error("clock out toggled early");
   a_master_clear_n_clears: assert property (disable iff (reset)
      !master_clear_n [*5] |-> fetch_word == 14'h0 && !pready)
      else $error("master clear ignored");
   a_fetch_cause: assert property ($changed(fetch_word) |->
      $past(fetch) || $past(fetch, 2))
      else $error("fetch word changed alone");
   a_daddr_cause: assert property ($changed(data_addr_out) |->
      $past(psel && penable && paddr == `MMBD_ADDR_DACC))
      else $error("data address changed alone");
endmodule
bind mmbd_memory_map_bank_decode mmbd_checker mmbd_checker_i (.clk, .reset,
   .master_clear_n, .psel, .penable, .pready, .pslverr, .fetch,
   .quarter_rate_clock_out, .paddr, .fetch_word, .data_addr_out);
`default_nettype wire

// ===== sim/mmbd_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module mmbd_core_model (
   input wire logic clk,
   output logic fetch, irq_take, pm_we,
   output logic [13:0] pm_wdata
);
   initial {fetch, irq_take, pm_we, pm_wdata} = '0;
   // One pulse; inverted data after it so a stale word never looks valid
   task automatic op(input logic [2:0] s, input logic [13:0] w);
      {pm_we, irq_take, fetch} <= s;
      pm_wdata <= w;
      @(posedge clk) {pm_we, irq_take, fetch} <= 3'h0;
      pm_wdata <= ~w;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "mmbd_consts.svh"
module tb_top;
   logic clk, reset, clk_en, master_clear_n, psel, penable, pwrite, pready;
   logic pslverr, quarter_rate_clock_out, fetch, irq_take, pm_we, q;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [13:0] pm_wdata, fetch_word;
   logic [8:0] data_addr_out;
   int errors, samples_checked, n;
   mmbd_memory_map_bank_decode mmbd_memory_map_bank_decode_i (.clk, .reset,
      .clk_en, .master_clear_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .fetch, .irq_take, .pm_wdata, .pm_we,
      .fetch_word, .quarter_rate_clock_out, .data_addr_out);
   mmbd_core_model mmbd_core_model_i (.clk, .fetch, .irq_take, .pm_we,
      .pm_wdata);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic stop_test;
      if (errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      n = 0;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      if (pready !== 1'b1) begin
         errors++;
         stop_test();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_reset;
      apb(0, `MMBD_ADDR_FLAGS, 0);
      chk(rd, 32'h18);
      apb(0, `MMBD_ADDR_PC, 0);
      chk(rd, 32'h0);
      apb(0, 12'h200, 0);
      chk(rd, 32'h0);
   endtask
   task automatic t_banks;
      for (int b = 0; b < 4; b++) begin
         apb(1, `MMBD_ADDR_FLAGS, b * 32 + 24);
         if (b < 2) apb(1, `MMBD_ADDR_DACC, 32'h2550 + b);
         else apb(0, `MMBD_ADDR_DACC, 32'h2500);
         if (b > 1) chk(rd, b * 32768 + 32'h254e + b);
         chk(data_addr_out, b * 128 + 37);
         apb(0, `MMBD_ADDR_DACC, 32'h0300);
         chk(rd, b * 32768 + 32'h0318 + b * 32);
      end
   endtask
   task automatic t_indirect;
      apb(1, `MMBD_ADDR_FLAGS, 32'h18);
      apb(1, `MMBD_ADDR_PTR, 32'h25);
      apb(0, `MMBD_ADDR_DACC, 0);
      chk(rd, 32'h2550);
   endtask
   task automatic t_pc;
      apb(1, `MMBD_ADDR_PCH, 32'h1f);
      apb(1, `MMBD_ADDR_PCL, 32'h34);
      apb(0, `MMBD_ADDR_PC, 0);
      chk(rd, 32'h1f34);
      mmbd_core_model_i.op(3'h2, 14'h0);
      apb(0, `MMBD_ADDR_PC, 0);
      chk(rd, 32'h4);
      apb(1, `MMBD_ADDR_PCH, 0);
      apb(1, `MMBD_ADDR_PCL, 5);
      mmbd_core_model_i.op(3'h4, 14'h2a5c);
      apb(1, `MMBD_ADDR_PCH, 8);
      apb(1, `MMBD_ADDR_PCL, 5);
      mmbd_core_model_i.op(3'h1, 14'h0);
      apb(0, `MMBD_ADDR_PMRD, 5);
      chk(rd, 32'h2a5c);
      chk(fetch_word, 14'h2a5c);
      apb(0, `MMBD_ADDR_PC, 0);
      chk(rd, 32'h806);
   endtask
   task automatic t_clkout;
      apb(1, `MMBD_ADDR_CTRL, 1);
      n = 0;
      @(negedge clk);
      q = quarter_rate_clock_out;
      repeat (32) begin
         @(negedge clk);
         if (quarter_rate_clock_out !== q) n++;
         q = quarter_rate_clock_out;
      end
      @(posedge clk);
      chk(n, 16);
   endtask
   task automatic t_master_clear_n;
      apb(1, `MMBD_ADDR_FLAGS, 32'h7f);
      master_clear_n <= 1'b0;
      repeat (6) @(posedge clk);
      master_clear_n <= 1'b1;
      repeat (4) @(posedge clk);
      apb(0, `MMBD_ADDR_FLAGS, 0);
      chk(rd, 32'h18);
   endtask
   initial begin
      {reset, clk_en, master_clear_n} = 3'h7;
      {psel, penable, pwrite, paddr, pwdata, errors, samples_checked} = '0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_banks();
      t_indirect();
      t_pc();
      t_clkout();
      t_master_clear_n();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      stop_test();
   end
endmodule
`default_nettype wire
